//--- src/psu_pkg.sv
// Functional notes
// R01 - Line low for the brown-out delay stops gate pulses.
// R02 - In brown-out, startup switch holds supply between 11.5 V and 12.5 V.
// R03 - After brown-out, switching resumes once line rises above brown-in level.
// R04 - Switching frequency is spread symmetrically around nominal.
// R05 - Spread stays active at every frequency, as a fixed 7 percent.
// R06 - Supply overvoltage held past 60 us latches shutdown; shorter blips ignored.
// R07 - Operation begins when rising supply reaches the start threshold.
// R08 - Supply at stop threshold halts operation and holds gate low.
// R09 - Entering lockout clears every latched protection state.
// R10 - In latch, startup switch holds supply between 8 V and 9 V.
// R11 - Latch is released only when supply falls below the off threshold.
// R12 - External latch pin low past 72 us latches shutdown.
// R13 - External latch pin high past 72 us latches shutdown.
// R14 - Nominal 65 kHz, reduced with light load, never below 25 kHz; with spread the code reaches 849 cycles, about 23.6 kHz.
// R15 - Feedback below burst level suspends switching; above it restarts.
// R16 - Feedback short comparator held for the short delay latches shutdown.
// R17 - Current-sense trip ends the gate pulse each cycle.
// R18 - Current sense is ignored during the minimum on-time.
// R19 - Line judged disconnected enables filter cap discharge.
// R20 - Line level kept in eight steps with hysteresis; a rise proves AC.
// R21 - No rise for a full detection delay starts filter cap discharge.
// R22 - Filters restart from zero on release; timers count clock cycles.
package psu_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int US_HZ  = 1_000_000;
    localparam int MS_HZ  = 1_000;
    localparam int NS_HZ  = 1_000_000_000;

    // Delay times; cycle counts round up so no filter is ever shorter
    localparam int BO_DELAY_MS   = 65;
    localparam int SC_DELAY_MS   = 64;
    localparam int AC_DELAY_MS   = 56;
    localparam int OV_DELAY_US   = 60;
    localparam int EXT_DELAY_US  = 72;
    localparam int MIN_ON_NS     = 300;
    localparam int BO_CYC_DEF    = (BO_DELAY_MS * (CLK_HZ / MS_HZ));
    localparam int SC_CYC_DEF    = (SC_DELAY_MS * (CLK_HZ / MS_HZ));
    localparam int AC_CYC_DEF    = (AC_DELAY_MS * (CLK_HZ / MS_HZ));
    localparam int OV_CYC        = (OV_DELAY_US * CLK_HZ + US_HZ - 1) / US_HZ;
    localparam int EXT_CYC       = (EXT_DELAY_US * CLK_HZ + US_HZ - 1) / US_HZ;
    localparam int MIN_ON_CYC    = (MIN_ON_NS * (CLK_HZ / US_HZ) + MS_HZ - 1) / MS_HZ;

    // Switching period in clock cycles
    localparam int NOM_FREQ_HZ   = 65_000;
    localparam int MIN_FREQ_HZ   = 25_000;
    localparam int PER_W         = 12;
    localparam int CALC_W        = 20;
    localparam logic [CALC_W-1:0] PER_NOM  = CALC_W'(CLK_HZ / NOM_FREQ_HZ);
    localparam logic [CALC_W-1:0] PER_MAX  = CALC_W'(CLK_HZ / MIN_FREQ_HZ);
    localparam logic [CALC_W-1:0] PCT_DIV  = 20'h00064;
    localparam logic [CALC_W-1:0] SPREAD_PCT  = 20'h00007;
    localparam logic [CALC_W-1:0] MAX_DUTY_PCT = 20'h00053;
    localparam int LD_W          = 8;
    localparam int SPREAD_W      = 5;
    localparam logic [SPREAD_W-1:0] SPREAD_TOP = 5'h10;
    localparam int SPREAD_SHIFT  = 3;

    // Protection filters
    localparam int CNT_W  = 21;
    localparam int FILT_N = 4;
    localparam int F_BO   = 0;
    localparam int F_OV   = 1;
    localparam int F_EXT  = 2;
    localparam int F_SC   = 3;
    localparam int CAUSE_W = 3;

    // Register map
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] PERIOD_ADDR = 8'h08;
    localparam int CTRL_EN_BIT   = 0;
    localparam int ST_MODE_LSB   = 0;
    localparam int ST_GATE_BIT   = 2;
    localparam int ST_START_BIT  = 3;
    localparam int ST_DSCH_BIT   = 4;
    localparam int ST_BURST_BIT  = 5;
    localparam int ST_CAUSE_LSB  = 8;

    typedef enum logic [1:0] {
        MODE_OFF      = 2'b00,
        MODE_RUN      = 2'b01,
        MODE_BROWNOUT = 2'b10,
        MODE_LATCH    = 2'b11
    } mode_t;

    // Comparator and quantiser outputs facing the block
    typedef struct packed {
        logic            line_sense_low;
        logic            line_sense_brownin;
        logic [2:0]      line_sense_level;
        logic            supply_at_start;
        logic            supply_below_off;
        logic            supply_below_lpl;
        logic            supply_above_lph;
        logic            supply_below_ll;
        logic            supply_above_lh;
        logic            supply_overvoltage;
        logic            external_latch_low;
        logic            external_latch_high;
        logic            feedback_burst_low;
        logic            feedback_short;
        logic [LD_W-1:0] feedback_level;
        logic            cs_trip;
    } sense_t;

    typedef struct packed {
        mode_t                        mode;
        logic [FILT_N-1:0][CNT_W-1:0] filt;
        logic [CNT_W-1:0]             ac_cnt;
        logic [2:0]                   lv_track;
        logic                         dsch;
        logic [PER_W-1:0]             phase;
        logic [PER_W-1:0]             period;
        logic [SPREAD_W-1:0]          spread_step;
        logic                         spread_down;
        logic                         gate;
        logic                         startup;
        logic [CAUSE_W-1:0]           cause;
        logic                         ctrl_en;
        logic                         ack;
        logic [31:0]                  rdata;
    } state_t;

    localparam state_t ST_RESET = '{
        mode    : MODE_OFF,
        period  : PER_W'(PER_NOM),
        startup : 1'h1,
        ctrl_en : 1'h1,
        default : '0
    };

endpackage

//--- src/psu_protection_sequencer.sv
`timescale 1ns/1ns
module psu_protection_sequencer
    import psu_pkg::*;
#(
    parameter int BO_CYC  = BO_CYC_DEF,
    parameter int SC_CYC  = SC_CYC_DEF,
    parameter int AC_CYC  = AC_CYC_DEF
)(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire sense_t      sense,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    output logic             gate_out,
    output logic             startup_on,
    output logic             filter_cap_discharge
);

    localparam logic [FILT_N-1:0][CNT_W-1:0] FILT_LIM = {
        CNT_W'(SC_CYC), CNT_W'(EXT_CYC), CNT_W'(OV_CYC), CNT_W'(BO_CYC)
    };
    localparam logic [CNT_W-1:0] AC_LIM  = CNT_W'(AC_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = 21'h000001;
    localparam logic [PER_W-1:0] PER_ONE = 12'h001;
    localparam logic [PER_W-1:0] MIN_ON_LAST = PER_W'(MIN_ON_CYC - 1);

    state_t                  st;
    state_t                  nx;
    logic [FILT_N-1:0]       trig;
    logic [FILT_N-1:0]       fire;
    logic                    latch_fire;
    logic                    lv_up;
    logic                    sw_ok;
    logic                    wrap;
    logic                    bus_req;
    logic [CALC_W-1:0]       base_per;
    logic [CALC_W-1:0]       dev;
    logic [CALC_W-1:0]       spread_off;
    logic [CALC_W-1:0]       new_per;
    logic [CALC_W-1:0]       max_on;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        nx = st;
        trig[F_BO]  = sense.line_sense_low;
        trig[F_OV]  = sense.supply_overvoltage;
        trig[F_EXT] = sense.external_latch_low | sense.external_latch_high;
        trig[F_SC]  = sense.feedback_short;

        // R22 filter restart
        for (int i = 0; i < FILT_N; i++)
        begin
            fire[i] = trig[i] && (st.mode != MODE_OFF) && (st.filt[i] == FILT_LIM[i] - CNT_ONE);
            if (!trig[i] || st.mode == MODE_OFF)
                nx.filt[i] = '0;
            else if (!fire[i])
                nx.filt[i] = st.filt[i] + CNT_ONE;
        end
        latch_fire = fire[F_OV] | fire[F_EXT] | fire[F_SC];

        case (st.mode)
            // R07 start threshold
            MODE_OFF:
            begin
                if (sense.supply_at_start)
                    nx.mode = MODE_RUN;
            end
            // R06 R12 R13 R16 latch entry, R01 brown-out
            MODE_RUN:
            begin
                if (latch_fire)
                    nx.mode = MODE_LATCH;
                else if (fire[F_BO])
                    nx.mode = MODE_BROWNOUT;
            end
            // R03 brown-in resume
            MODE_BROWNOUT:
            begin
                if (latch_fire)
                    nx.mode = MODE_LATCH;
                else if (sense.line_sense_brownin)
                    nx.mode = MODE_RUN;
            end
            MODE_LATCH:
            begin
                nx.mode = MODE_LATCH;
            end
            default:
            begin
                nx.mode = MODE_OFF;
            end
        endcase
        nx.cause = st.cause | {fire[F_SC], fire[F_EXT], fire[F_OV]};

        // R08 R09 R11 lockout wins and clears latches
        if (sense.supply_below_off)
        begin
            nx.mode  = MODE_OFF;
            nx.cause = '0;
        end

        // R02 R10 startup switch hysteresis
        case (nx.mode)
            MODE_OFF:
            begin
                nx.startup = 1'h1;
            end
            MODE_RUN:
            begin
                nx.startup = 1'h0;
            end
            MODE_BROWNOUT:
            begin
                if (sense.supply_below_lpl)
                    nx.startup = 1'h1;
                else if (sense.supply_above_lph)
                    nx.startup = 1'h0;
            end
            MODE_LATCH:
            begin
                if (sense.supply_below_ll)
                    nx.startup = 1'h1;
                else if (sense.supply_above_lh)
                    nx.startup = 1'h0;
            end
            default:
            begin
                nx.startup = 1'h1;
            end
        endcase

        // R20 level tracking; a one-step fall is absorbed by hysteresis
        lv_up = sense.line_sense_level > st.lv_track;
        if (lv_up)
            nx.lv_track = sense.line_sense_level;
        else if ({1'b0, sense.line_sense_level} + 4'h1 < {1'b0, st.lv_track})
            nx.lv_track = sense.line_sense_level;

        // R19 R21 discharge after a silent window
        if (lv_up)
        begin
            nx.ac_cnt = '0;
            nx.dsch   = 1'h0;
        end
        else if (st.ac_cnt == AC_LIM - CNT_ONE)
            nx.dsch = 1'h1;
        else
            nx.ac_cnt = st.ac_cnt + CNT_ONE;

        // R14 period follows feedback between nominal and minimum frequency
        base_per = PER_MAX
                 - (((PER_MAX - PER_NOM) * CALC_W'(sense.feedback_level)) >> LD_W);
        // R04 R05 symmetric spread as a percentage of the feedback-derived base period
        dev        = (base_per * SPREAD_PCT) / PCT_DIV;
        spread_off = (dev * CALC_W'(st.spread_step)) >> SPREAD_SHIFT;
        new_per    = base_per + spread_off - dev;
        max_on     = (CALC_W'(st.period) * MAX_DUTY_PCT) / PCT_DIV;

        // R15 burst gating
        sw_ok = (nx.mode == MODE_RUN) && st.ctrl_en && !sense.feedback_burst_low;
        wrap  = st.phase >= st.period - PER_ONE;

        if (wrap)
        begin
            nx.phase  = '0;
            nx.period = PER_W'(new_per);
            nx.gate   = sw_ok;
            if (!st.spread_down && st.spread_step == SPREAD_TOP - 5'h01)
                nx.spread_down = 1'h1;
            else if (st.spread_down && st.spread_step == 5'h01)
                nx.spread_down = 1'h0;
            if (nx.spread_down)
                nx.spread_step = st.spread_step - 5'h01;
            else
                nx.spread_step = st.spread_step + 5'h01;
        end
        else
        begin
            nx.phase = st.phase + PER_ONE;
            if (!sw_ok)
                nx.gate = 1'h0;
            // R17 R18 current sense honoured only after minimum on-time
            else if (sense.cs_trip && st.phase >= MIN_ON_LAST)
                nx.gate = 1'h0;
            else if (CALC_W'(st.phase) >= max_on)
                nx.gate = 1'h0;
        end

        // Bus slave: ack one cycle after the strobe, dropped the next cycle
        bus_req = wb_cyc_i && wb_stb_i && !st.ack;
        nx.ack  = bus_req;
        if (bus_req)
        begin
            nx.rdata = '0;
            if (wb_we_i && wb_adr_i == CTRL_ADDR && wb_sel_i[0])
                nx.ctrl_en = wb_dat_i[CTRL_EN_BIT];
            case (wb_adr_i)
                CTRL_ADDR:
                begin
                    nx.rdata[CTRL_EN_BIT] = st.ctrl_en;
                end
                STATUS_ADDR:
                begin
                    nx.rdata[ST_MODE_LSB +: 2]       = st.mode;
                    nx.rdata[ST_GATE_BIT]            = st.gate;
                    nx.rdata[ST_START_BIT]           = st.startup;
                    nx.rdata[ST_DSCH_BIT]            = st.dsch;
                    nx.rdata[ST_BURST_BIT]           = sense.feedback_burst_low;
                    nx.rdata[ST_CAUSE_LSB +: CAUSE_W] = st.cause;
                end
                PERIOD_ADDR:
                begin
                    nx.rdata[PER_W-1:0] = st.period;
                end
                default:
                begin
                    nx.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st <= ST_RESET;
        else
            st <= nx;
    end

    assign gate_out             = st.gate;
    assign startup_on           = st.startup;
    assign filter_cap_discharge = st.dsch;
    assign wb_ack_o             = st.ack;
    assign wb_dat_o             = st.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_bo_expire;
        st.mode == MODE_RUN && fire[F_BO] && !latch_fire && !sense.supply_below_off;
    endsequence

    sequence s_latch_cause;
        st.mode != MODE_OFF && latch_fire && !sense.supply_below_off;
    endsequence

    property p_brownout_stop;
        s_bo_expire |=> st.mode == MODE_BROWNOUT ##0 !gate_out;
    endproperty
    a_brownout_stop: assert property (p_brownout_stop) else $error("no brown-out stop"); // R01

    property p_latch_entry;
        s_latch_cause |=> st.mode == MODE_LATCH && st.cause != '0;
    endproperty
    a_latch_entry: assert property (p_latch_entry) else $error("latch not entered"); // R06

    property p_ov_filter;
        sense.supply_overvoltage && st.mode == MODE_RUN && st.filt[F_OV] == '0
            |-> st.mode != MODE_LATCH [*2];
    endproperty
    a_ov_filter: assert property (p_ov_filter) else $error("overvoltage latched early"); // R22

    property p_lockout;
        sense.supply_below_off |=> st.mode == MODE_OFF && st.cause == '0 && !gate_out;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout not taken"); // R09

    property p_gate_off;
        st.mode != MODE_RUN |-> !gate_out;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate high outside run"); // R08

    property p_brownin;
        st.mode == MODE_BROWNOUT && sense.line_sense_brownin && !latch_fire
            && !sense.supply_below_off |=> st.mode == MODE_RUN;
    endproperty
    a_brownin: assert property (p_brownin) else $error("no brown-in resume"); // R03

    property p_cs_end;
        gate_out && sense.cs_trip && st.phase >= MIN_ON_LAST && !wrap |=> !gate_out;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("pulse not ended by cs"); // R17

    property p_min_on;
        gate_out && st.phase < MIN_ON_LAST && sw_ok && !wrap |=> gate_out;
    endproperty
    a_min_on: assert property (p_min_on) else $error("pulse cut in blanking"); // R18

    property p_latch_hold;
        st.mode == MODE_LATCH && sense.supply_below_ll && !sense.supply_below_off
            |=> startup_on;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch supply not held"); // R10

    property p_bo_hold;
        st.mode == MODE_BROWNOUT && sense.supply_above_lph && !sense.supply_below_lpl
            && !sense.line_sense_brownin |=> !startup_on;
    endproperty
    a_bo_hold: assert property (p_bo_hold) else $error("brown-out supply not held"); // R02

    property p_dsch;
        st.ac_cnt == AC_LIM - CNT_ONE && !lv_up |=> filter_cap_discharge;
    endproperty
    a_dsch: assert property (p_dsch) else $error("discharge not started"); // R21

    property p_ac_seen;
        lv_up |=> !filter_cap_discharge && st.ac_cnt == '0;
    endproperty
    a_ac_seen: assert property (p_ac_seen) else $error("AC rise not honoured"); // R20

    property p_period_span;
        st.period <= PER_W'(PER_MAX + PER_MAX / 10) && st.period >= PER_W'(PER_NOM - PER_NOM / 10);
    endproperty
    a_period_span: assert property (p_period_span) else $error("period out of range"); // R14

endmodule

//--- tb/psu_frontend_model.sv
`timescale 1ns/1ns
module psu_frontend_model
    import psu_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   power,
    input  wire logic   startup_on,
    input  wire logic   gate_out,
    input  wire sense_t drv,
    output sense_t      sense_o,
    output int          vcc
);
    // Rail in tenths of a volt; slow droop so the first pulse can take over
    int         idle;
    logic [2:0] div;

    initial
    begin
        vcc = 0;
        idle = 5000;
        div = 3'h0;
    end

    always @(posedge sys_clk)
    begin
        div <= div + 3'h1;
        idle <= gate_out ? 0 : idle + 1;
        if (power && startup_on)
            vcc <= vcc + 1;
        else if (idle < 1000)
            vcc <= 150;
        else if (div == 3'h0 && vcc > 0)
            vcc <= vcc - 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Supply comparators; the rest comes straight from the bench
    always_comb
    begin
        sense_o = drv;
        sense_o.supply_at_start  = (vcc >= 150);
        sense_o.supply_below_off = (vcc <= 65);
        sense_o.supply_below_lpl = (vcc < 115);
        sense_o.supply_above_lph = (vcc > 125);
        sense_o.supply_below_ll  = (vcc < 80);
        sense_o.supply_above_lh  = (vcc > 90);
    end
endmodule

//--- tb/psu_protection_sequencer_tb.sv
`timescale 1ns/1ns
module psu_protection_sequencer_tb;
    import psu_pkg::*;

    localparam int BO_N  = 200;
    localparam int SC_N  = 150;
    localparam int AC_N  = 300;

    logic        sys_clk;
    logic        rst;
    logic        power;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic        gate_out;
    logic        startup_on;
    logic        filter_cap_discharge;
    sense_t      drv;
    sense_t      sense;
    int          vcc;
    int          error_cnt;
    int          num_checks;

    psu_protection_sequencer #(.BO_CYC(BO_N), .SC_CYC(SC_N), .AC_CYC(AC_N))
    psu_protection_sequencer_i (
        .sys_clk(sys_clk), .rst(rst), .sense(sense), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .gate_out(gate_out), .startup_on(startup_on),
        .filter_cap_discharge(filter_cap_discharge)
    );

    psu_frontend_model psu_frontend_model_i (
        .sys_clk(sys_clk), .power(power), .startup_on(startup_on),
        .gate_out(gate_out), .drv(drv), .sense_o(sense), .vcc(vcc)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic timeout();
        error_cnt++;
        $display("wait limit ran out");
        give_verdict();
    endtask

    // Ack is sampled at the rising edge; data is taken and the request released there
    task automatic wb(logic we, logic [7:0] adr, logic [31:0] wd, output logic [31:0] rd);
        int i;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        i = 0;
        do
        begin
            @(posedge sys_clk);
            i++;
        end
        while (wb_ack_o !== 1'b1 && i < 50);
        if (wb_ack_o !== 1'b1)
            timeout();
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd(logic [7:0] adr, output logic [31:0] d);
        wb(1'b0, adr, 32'h0, d);
    endtask

    task automatic wait_gate();
        int i;
        for (i = 0; i < 4000 && gate_out === 1'b1; i++) @(negedge sys_clk);
        for (i = 0; i < 4000 && gate_out !== 1'b1; i++) @(negedge sys_clk);
        if (gate_out !== 1'b1)
            timeout();
    endtask

    task automatic setf(int k, logic v);
        case (k)
            0: drv.line_sense_low <= v;
            1: drv.supply_overvoltage <= v;
            2: drv.external_latch_low <= v;
            3: drv.external_latch_high <= v;
            default: drv.feedback_short <= v;
        endcase
    endtask

    task automatic pulse(int k, int n);
        @(posedge sys_clk);
        setf(k, 1'b1);
        repeat (n) @(posedge sys_clk);
        setf(k, 1'b0);
    endtask

    // Rail must stay in the band and actually move, i.e. the switch cycles
    task automatic rail(int lo, int hi, string nm);
        int mn;
        int mx;
        mn = 999;
        mx = 0;
        repeat (2000) @(posedge sys_clk);
        repeat (600)
        begin
            @(negedge sys_clk);
            if (vcc < mn)
                mn = vcc;
            if (vcc > mx)
                mx = vcc;
        end
        check(nm, (mn >= lo && mx <= hi && mx - mn >= 8), 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] d;
        logic [31:0] mn;
        logic [31:0] mx;
        logic [7:0]  fb;
        int          k;
        int          n;
        int          base;
        int          dev;
        void'($urandom(56526));
        error_cnt = 0;
        num_checks = 0;
        rst = 1'b1;
        power = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        drv = '0;
        drv.line_sense_level = 3'h3;
        drv.feedback_level = 8'hff;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check("gate", gate_out, 1'b0);
        check("startup", startup_on, 1'b1);
        rd(CTRL_ADDR, d);
        check("ctrl", d, 32'h1);
        rd(STATUS_ADDR, d);
        check("status", d, 32'h8);
        rd(PERIOD_ADDR, d);
        check("period", d, 32'h133);
        rd(8'h0c, d);
        check("unmapped", d, 32'h0);
        $display("test reset done");

        power <= 1'b1;
        wait_gate();
        wb(1'b1, STATUS_ADDR, 32'h3, d);
        rd(STATUS_ADDR, d);
        check("run", d[1:0], MODE_RUN);
        @(posedge sys_clk);
        drv.cs_trip <= 1'b1;
        wait_gate();
        for (n = 0; n < 900 && gate_out === 1'b1; n++) @(negedge sys_clk);
        check("min on", n, MIN_ON_CYC);
        @(posedge sys_clk);
        drv.cs_trip <= 1'b0;
        $display("test start done");

        for (k = 0; k < 4; k++)
        begin
            fb = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            @(posedge sys_clk);
            drv.feedback_level <= fb;
            base = 800 - ((493 * fb) >> 8);
            dev = base * 7 / 100;
            mn = 32'hffff;
            mx = 32'h0;
            repeat (3)
            begin
                repeat (2000) @(posedge sys_clk);
                rd(PERIOD_ADDR, d);
                mn = (d < mn) ? d : mn;
                mx = (d > mx) ? d : mx;
            end
            check("spread", (mn >= base - dev && mx <= base + dev && mx > mn), 1'b1);
        end
        // Short period again, so long gate-off stretches do not drain the rail
        drv.feedback_level <= 8'hff;
        $display("test period done");

        for (k = 0; k < 2; k++)
        begin
            if (k == 0)
                wb(1'b1, CTRL_ADDR, 32'h0, d);
            else
            begin
                @(posedge sys_clk);
                drv.feedback_burst_low <= 1'b1;
            end
            repeat (3) @(posedge sys_clk);
            n = 0;
            repeat (900)
            begin
                @(negedge sys_clk);
                n += int'(gate_out !== 1'b0);
            end
            check("blocked", n, 0);
            if (k == 0)
                wb(1'b1, CTRL_ADDR, 32'h1, d);
            else
            begin
                @(posedge sys_clk);
                drv.feedback_burst_low <= 1'b0;
            end
            wait_gate();
        end
        $display("test block done");

        for (k = 1; k < 5; k++)
        begin
            n = (k == 1) ? OV_CYC : (k == 4) ? SC_N : EXT_CYC;
            pulse(k, n - 1);
            rd(STATUS_ADDR, d);
            check("short", d[1:0], MODE_RUN);
            pulse(k, n);
            rd(STATUS_ADDR, d);
            check("latch", d[2:0], {1'b0, MODE_LATCH});
            check("cause", d[10:8], (k == 1) ? 3'h1 : (k == 4) ? 3'h4 : 3'h2);
            rail(76, 94, "latch rail");
            rd(STATUS_ADDR, d);
            check("held", d[1:0], MODE_LATCH);
            @(posedge sys_clk);
            power <= 1'b0;
            repeat (400) @(posedge sys_clk);
            rd(STATUS_ADDR, d);
            check("off", {d[10:8], d[2:0]}, 6'h0);
            @(posedge sys_clk);
            power <= 1'b1;
            wait_gate();
        end
        $display("test latch done");

        pulse(0, BO_N - 1);
        rd(STATUS_ADDR, d);
        check("bo short", d[1:0], MODE_RUN);
        @(posedge sys_clk);
        drv.line_sense_low <= 1'b1;
        repeat (BO_N + 2) @(posedge sys_clk);
        rd(STATUS_ADDR, d);
        check("bo", d[2:0], {1'b0, MODE_BROWNOUT});
        rail(111, 129, "bo rail");
        @(posedge sys_clk);
        drv.line_sense_low <= 1'b0;
        drv.line_sense_brownin <= 1'b1;
        wait_gate();
        rd(STATUS_ADDR, d);
        check("bi", d[1:0], MODE_RUN);
        $display("test brownout done");

        @(posedge sys_clk);
        drv.line_sense_level <= 3'h4;
        repeat (AC_N - 20) @(posedge sys_clk);
        @(negedge sys_clk);
        check("ac early", filter_cap_discharge, 1'b0);
        repeat (40) @(posedge sys_clk);
        @(negedge sys_clk);
        check("ac lost", filter_cap_discharge, 1'b1);
        @(posedge sys_clk);
        drv.line_sense_level <= 3'h5;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        check("ac back", filter_cap_discharge, 1'b0);
        $display("test discharge done");
        give_verdict();
    end
endmodule
